// ### swg_core.sv
// Set-value waveform generator with a classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "swg_params.svh"
module swg_core (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire swg_pkg::swg_word_t dat_i,
  output logic                   ack_o,
  output swg_pkg::swg_word_t     dat_o,
  // Protection and mode pins, asynchronous
  input  wire logic              dev_alarm_i,
  input  wire logic              overpower_trip_i,
  input  wire logic              overcurrent_trip_i,
  input  wire logic              event_alarm_i,
  input  wire logic              resist_mode_i,
  // Regulator set values and status
  output swg_pkg::swg_level_t    u_set_o,
  output swg_pkg::swg_level_t    i_set_o,
  output swg_pkg::swg_level_t    p_set_o,
  output logic                   out_en_o,
  output logic                   running_o,
  output logic                   alarm_o
);
  import swg_pkg::*;

  localparam logic [11:0] TICK_LAST = 12'(`SWG_TICK_CYC - 1);
  localparam logic [31:0] PH_STEP   = 32'(`SWG_PH_PER_HZ);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a[7:2] == o[7:2];
  endfunction : hit

  function automatic logic t_ok(input logic [28:0] t);
    return t >= `SWG_T_MIN && t <= `SWG_T_MAX;
  endfunction : t_ok

  // Pin synchronisers; only the second stage is read
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
    end else begin
      pin_s1_q <= {resist_mode_i, event_alarm_i, overcurrent_trip_i,
                   overpower_trip_i, dev_alarm_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire alarm_any = |pin_s2_q[3:0];
  wire resist    = pin_s2_q[4];

  // Bus decode; a write lands on the edge where ack rises
  logic      ack_q;
  swg_word_t dat_q;
  wire       bus_req = cyc_i & stb_i & ~ack_q;
  wire       wr      = bus_req & we_i;
  wire [31:0] be_m   = {{8{sel_i[3]}}, {8{sel_i[2]}},
                        {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire       par_we  = wr & ~out_en_o;
  wire       cmd_wr  = wr & hit(adr_i, `SWG_A_CMD) & sel_i[0];
  wire       load_p  = cmd_wr & dat_i[`SWG_CMD_LOAD];
  wire       start_p = cmd_wr & dat_i[`SWG_CMD_START];
  wire       stop_p  = cmd_wr & dat_i[`SWG_CMD_STOP];
  wire       onoff_p = cmd_wr & dat_i[`SWG_CMD_ONOFF];
  wire       clr_al  = cmd_wr & dat_i[`SWG_CMD_CLRAL];
  wire       clr_er  = cmd_wr & dat_i[`SWG_CMD_CLRER];

  function automatic swg_word_t upd(input swg_word_t old);
    return (old & ~be_m) | (dat_i & be_m);
  endfunction : upd

  // Staged parameters, writable only while the output is off
  logic [2:0]  ctrl_q;
  swg_level_t  amp_q, offs_q, su_q, si_q, sp_q;
  logic [13:0] freq_q;
  logic [28:0] t_q [4];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 3'h0;
      amp_q  <= `SWG_RST_LEVEL;
      offs_q <= `SWG_RST_LEVEL;
      freq_q <= `SWG_RST_FREQ;
      su_q   <= `SWG_RST_LEVEL;
      si_q   <= `SWG_RST_LEVEL;
      sp_q   <= `SWG_RST_LEVEL;
    end else if (par_we) begin
      if (hit(adr_i, `SWG_A_CTRL) && !resist)
        ctrl_q <= 3'(upd(32'(ctrl_q)));
      if (hit(adr_i, `SWG_A_AMPL)) amp_q <= 16'(upd(32'(amp_q)));
      if (hit(adr_i, `SWG_A_OFFS)) offs_q <= 16'(upd(32'(offs_q)));
      if (hit(adr_i, `SWG_A_FREQ)) freq_q <= 14'(upd(32'(freq_q)));
      if (hit(adr_i, `SWG_A_USTAT)) su_q <= 16'(upd(32'(su_q)));
      if (hit(adr_i, `SWG_A_ISTAT)) si_q <= 16'(upd(32'(si_q)));
      if (hit(adr_i, `SWG_A_PSTAT)) sp_q <= 16'(upd(32'(sp_q)));
    end
  end

  // Four interval registers, one word each from T1 upward
  for (genvar g = 0; g < 4; g++) begin : g_tw
    always_ff @(posedge clk_i) begin
      if (rst_i)
        t_q[g] <= `SWG_RST_T;
      else if (par_we && hit(adr_i, `SWG_A_T1 + 8'(4 * g)))
        t_q[g] <= 29'(upd(32'(t_q[g])));
    end
  end

  // Range checks made before a load is accepted
  wire [16:0] span_w  = {1'b0, offs_q} + {1'b0, amp_q};
  wire ok_span = span_w <= `SWG_NOMINAL;
  wire ok_sine = offs_q >= amp_q
               && freq_q >= `SWG_F_MIN && freq_q <= `SWG_F_MAX;
  wire ok_t    = t_ok(t_q[0]) && t_ok(t_q[1])
               && (ctrl_q[1:0] != SWG_TRAP
                   || (t_ok(t_q[2]) && t_ok(t_q[3])));
  wire par_ok  = ok_span && (ctrl_q[1:0] == SWG_SINE ? ok_sine : ok_t);

  // Sequencer
  swg_state_e state_q, state_d;
  wire idle_off = state_q == SWG_IDLE || state_q == SWG_OFF;
  wire go_ok    = ~resist & ~alarm_any;
  wire load_go  = load_p & idle_off & par_ok & go_ok;
  wire start_go = (start_p | onoff_p) & go_ok;
  always_comb begin
    state_d = state_q;
    case (state_q)
      SWG_IDLE: begin
        if (load_go) state_d = SWG_LOAD;
      end
      SWG_LOAD: begin
        state_d = SWG_ARMED;
      end
      SWG_ARMED: begin
        if (onoff_p) state_d = SWG_OFF;
        else if (start_p && go_ok) state_d = SWG_RUN;
      end
      SWG_RUN: begin
        if (onoff_p) state_d = SWG_OFF;
        else if (stop_p) state_d = SWG_ARMED;
      end
      SWG_OFF: begin
        if (load_go) state_d = SWG_LOAD;
        else if (start_go) state_d = SWG_RUN;
      end
      default: state_d = SWG_IDLE;
    endcase
    if (alarm_any && state_q != SWG_IDLE) state_d = SWG_OFF;
  end
  wire run       = state_q == SWG_RUN;
  wire start_run = state_d == SWG_RUN && !run;
  wire refuse    = start_p & ((state_q == SWG_IDLE) | (state_q == SWG_LOAD)
                              | ~go_ok);
  wire reject    = load_p & ~load_go;

  // State, output enable and sticky flags; a set beats a clear
  logic refused_q, rejected_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= SWG_IDLE;
      out_en_o   <= 1'b0;
      running_o  <= 1'b0;
      alarm_o    <= 1'b0;
      refused_q  <= 1'b0;
      rejected_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      out_en_o   <= state_d == SWG_ARMED || state_d == SWG_RUN;
      running_o  <= state_d == SWG_RUN;
      alarm_o    <= alarm_any | (alarm_o & ~clr_al);
      refused_q  <= refuse | (refused_q & ~clr_er);
      rejected_q <= reject | (rejected_q & ~clr_er);
    end
  end

  // Working copy taken at load; a running waveform never sees edits
  logic       w_tgt_q;
  swg_wave_e  w_wave_q;
  swg_level_t w_amp_q, w_offs_q, w_u_q, w_i_q, w_p_q;
  logic [31:0] w_inc_q;
  logic [28:0] w_t_q [4];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_tgt_q  <= 1'b0;
      w_wave_q <= SWG_SINE;
      w_amp_q  <= `SWG_RST_LEVEL;
      w_offs_q <= `SWG_RST_LEVEL;
      w_u_q    <= `SWG_RST_LEVEL;
      w_i_q    <= `SWG_RST_LEVEL;
      w_p_q    <= `SWG_RST_LEVEL;
      w_inc_q  <= 32'h00000000;
      w_t_q    <= '{default: `SWG_RST_T};
    end else if (load_go) begin
      w_tgt_q  <= ctrl_q[`SWG_CTRL_TGT];
      w_wave_q <= swg_wave_e'(ctrl_q[1:0]);
      w_amp_q  <= amp_q;
      w_offs_q <= offs_q;
      w_u_q    <= su_q;
      w_i_q    <= si_q;
      w_p_q    <= sp_q;
      w_inc_q  <= 32'(freq_q) * PH_STEP;
      w_t_q    <= t_q;
    end
  end

  // Common 0.1 ms timebase, restarted with each run
  logic [11:0] tick_cnt_q;
  logic [28:0] el_q;
  logic [1:0]  ph_q;
  logic        div_go_q;
  wire tick_w = run && tick_cnt_q == TICK_LAST;
  wire [28:0] cur_t = w_t_q[ph_q];
  wire [28:0] el_nx = el_q + 29'd1;
  wire seg_end = el_nx == cur_t;
  wire [1:0] ph_last = w_wave_q == SWG_TRAP ? 2'h3 : 2'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i || start_run) begin
      tick_cnt_q <= 12'h000;
      el_q       <= 29'h0000000;
      ph_q       <= 2'h0;
    end else if (tick_w) begin
      tick_cnt_q <= 12'h000;
      el_q       <= seg_end ? 29'h0000000 : el_nx;
      if (seg_end)
        ph_q <= ph_q == ph_last ? 2'h0 : ph_q + 2'h1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 12'h001;
    end
  end

  // Divider for amp*elapsed/interval; 16 steps fit well inside a tick
  logic [44:0] rem_q;
  swg_level_t  quo_q;
  logic [4:0]  dcnt_q;
  logic        done_q;
  wire [44:0] dsh_w = {cur_t, 16'h0000} >> (5'd17 - dcnt_q);
  wire        ge_w  = rem_q >= dsh_w;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_go_q <= 1'b0;
      rem_q    <= 45'h0;
      quo_q    <= 16'h0000;
      dcnt_q   <= 5'h00;
      done_q   <= 1'b0;
    end else begin
      div_go_q <= tick_w | start_run;
      done_q   <= dcnt_q == 5'h01;
      if (div_go_q) begin
        rem_q  <= 45'(w_amp_q) * 45'(el_q);
        dcnt_q <= 5'h10;
      end else if (dcnt_q != 5'h00) begin
        rem_q  <= ge_w ? rem_q - dsh_w : rem_q;
        quo_q  <= {quo_q[14:0], ge_w};
        dcnt_q <= dcnt_q - 5'h01;
      end
    end
  end

  // Segment kind: 0 rise, 1 top, 2 fall, 3 foot
  wire [1:0] kind = w_wave_q == SWG_TRI  ? {ph_q[0], 1'b0}
                  : w_wave_q == SWG_RECT ? {ph_q[0], 1'b1}
                  : ph_q;
  wire [15:0] top_w = w_offs_q + w_amp_q;
  wire [15:0] ramp_w = kind == 2'h0 ? w_offs_q + quo_q
                     : kind == 2'h1 ? top_w
                     : kind == 2'h2 ? top_w - quo_q
                     : w_offs_q;

  // Sine by parabola per half wave; coarse but needs no table
  logic [31:0] ph_acc_q;
  logic [14:0] mag_q;
  logic        half_q;
  wire [15:0] x_w   = ph_acc_q[30:15];
  wire [31:0] sq_w  = 32'(x_w) * 32'(16'hFFFF - x_w);
  wire [30:0] tm_w  = 31'(w_amp_q) * 31'(mag_q);
  wire [15:0] sin_w = half_q ? w_offs_q - tm_w[30:15]
                             : w_offs_q + tm_w[30:15];
  wire is_sine = w_wave_q == SWG_SINE;

  // Waveform level and its validity within the run
  swg_level_t lvl_q;
  logic       lvl_ok_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !run) begin
      ph_acc_q <= 32'h00000000;
      mag_q    <= 15'h0000;
      half_q   <= 1'b0;
      lvl_q    <= `SWG_RST_LEVEL;
      lvl_ok_q <= 1'b0;
    end else begin
      ph_acc_q <= ph_acc_q + w_inc_q;
      mag_q    <= sq_w[29:15];
      half_q   <= ph_acc_q[31];
      if (is_sine) lvl_q <= sin_w;
      else if (done_q) lvl_q <= ramp_w;
      lvl_ok_q <= lvl_ok_q | done_q | is_sine;
    end
  end

  // Set values: waveform on the chosen one, the rest as static limits
  wire live = run && lvl_ok_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      u_set_o <= `SWG_RST_LEVEL;
      i_set_o <= `SWG_RST_LEVEL;
      p_set_o <= `SWG_RST_LEVEL;
    end else begin
      u_set_o <= (live && !w_tgt_q) ? lvl_q : w_u_q;
      i_set_o <= (live && w_tgt_q) ? lvl_q
               : (w_tgt_q ? `SWG_RST_LEVEL : w_i_q);
      p_set_o <= w_p_q;
    end
  end

  // Read mux and ack; unmapped words read zero
  wire [31:0] st_w = 32'({resist, rejected_q, refused_q, alarm_o,
                          running_o, out_en_o, state_q});
  wire [31:0] rd_w =
      hit(adr_i, `SWG_A_CTRL)   ? 32'(ctrl_q)
    : hit(adr_i, `SWG_A_STATUS) ? st_w
    : hit(adr_i, `SWG_A_AMPL)   ? 32'(amp_q)
    : hit(adr_i, `SWG_A_OFFS)   ? 32'(offs_q)
    : hit(adr_i, `SWG_A_FREQ)   ? 32'(freq_q)
    : hit(adr_i, `SWG_A_USTAT)  ? 32'(su_q)
    : hit(adr_i, `SWG_A_ISTAT)  ? 32'(si_q)
    : hit(adr_i, `SWG_A_PSTAT)  ? 32'(sp_q)
    : (adr_i >= `SWG_A_T1 && adr_i < `SWG_A_USTAT)
                                ? 32'(t_q[adr_i[3:2] - 2'h2])
    : 32'h00000000;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req;
      dat_q <= (bus_req && !we_i) ? rd_w : 32'h00000000;
    end
  end
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // Checks on the sequencer and the generated levels
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_load_order: assert property (state_q == SWG_LOAD && !alarm_any
    |=> state_q == SWG_ARMED && out_en_o)
    else $error("load did not arm with output on");
  a_start_refused: assert property (state_q == SWG_IDLE
    |=> state_q != SWG_RUN && !running_o)
    else $error("start accepted before load");
  a_stop_static: assert property (run && stop_p && !onoff_p
    && !alarm_any |=> ##1 out_en_o && !running_o
    && (w_tgt_q || u_set_o == w_u_q))
    else $error("stop did not return to static values");
  a_i_from_zero: assert property (state_q == SWG_ARMED
    && $past(state_q) == SWG_ARMED && w_tgt_q |-> i_set_o == 16'h0000)
    else $error("static current not zero");
  a_start_now: assert property (state_q == SWG_ARMED && start_p
    && !onoff_p && go_ok |=> running_o && out_en_o)
    else $error("start not immediate");
  a_onoff_halt: assert property (run && onoff_p
    |=> !out_en_o && !running_o)
    else $error("on/off did not disable output");
  a_alarm_halt: assert property (alarm_any
    |=> !out_en_o && !running_o && alarm_o)
    else $error("alarm did not halt output");
  a_sine_span: assert property (live && is_sine
    |-> {1'b0, lvl_q} <= {1'b0, w_offs_q} + {1'b0, w_amp_q}
     && {1'b0, lvl_q} + {1'b0, w_amp_q} >= {1'b0, w_offs_q})
    else $error("sine outside offset plus amplitude");
  a_phase_wrap: assert property (tick_w && seg_end
    && ph_q == ph_last |=> ph_q == 2'h0 && el_q == 29'h0000000)
    else $error("period did not restart");
  a_tick_space: assert property (tick_w |=> !tick_w [*8])
    else $error("timebase ticks too close");
  a_param_lock: assert property (out_en_o && wr
    && hit(adr_i, `SWG_A_AMPL) |=> $stable(amp_q))
    else $error("parameter changed while output on");
  a_resist_block: assert property (resist && idle_off
    |=> idle_off)
    else $error("load accepted in resistance mode");
  a_current_only: assert property (running_o && w_tgt_q
    |-> u_set_o == w_u_q && p_set_o == w_p_q)
    else $error("static limit moved by current waveform");
  a_sine_apply: assert property (live && is_sine && !w_tgt_q
    |=> u_set_o == $past(lvl_q))
    else $error("sine not applied to voltage");
endmodule : swg_core
`default_nettype wire

// ### swg_core_tb.sv
// Self-checking bench for the set-value waveform generator
`timescale 1ns/1ps
`default_nettype none
`include "swg_params.svh"
module swg_core_tb;
  import swg_pkg::*;
  localparam swg_level_t ST_U = 16'h1000;
  localparam swg_level_t OFFS = 16'h0100;
  localparam swg_level_t AMP  = 16'h0200;
  logic       clk_i, rst_i, cyc_i, stb_i, we_i, resist_mode_i, ack_o;
  logic       out_en_o, running_o, alarm_o, dev_al, op_tr, oc_tr, ev_al;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [2:0] trip_sel;
  swg_word_t  dat_i, dat_o, rd;
  swg_level_t u_set_o, i_set_o, p_set_o;
  int         bad_count, total_checks, n;

  swg_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o), .dev_alarm_i(dev_al),
    .overpower_trip_i(op_tr), .overcurrent_trip_i(oc_tr),
    .event_alarm_i(ev_al), .resist_mode_i(resist_mode_i),
    .u_set_o(u_set_o), .i_set_o(i_set_o), .p_set_o(p_set_o),
    .out_en_o(out_en_o), .running_o(running_o), .alarm_o(alarm_o));

  swg_stage_model stage_u (.clk_i(clk_i), .trip_sel_i(trip_sel),
    .dev_alarm_o(dev_al), .overpower_trip_o(op_tr),
    .overcurrent_trip_o(oc_tr), .event_alarm_o(ev_al));

  // Clock at 25 MHz
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input swg_word_t seen, input swg_word_t exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle: hold everything until ack is sampled high; only the
  // bench ceiling ends a wait that never gets its answer
  task automatic wb(input logic w, input logic [7:0] a, input swg_word_t d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  task automatic cmd(input int b);
    wb(1'b1, `SWG_A_CMD, 32'h1 << b);
    repeat (3) @(posedge clk_i);
  endtask : cmd

  task automatic load_expect(input logic ok);
    cmd(`SWG_CMD_CLRER);
    cmd(`SWG_CMD_LOAD);
    wb(1'b0, `SWG_A_STATUS, 32'h0);
  endtask : load_expect

  task automatic t_idle;
    wb(1'b0, `SWG_A_STATUS, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 8'h3C, 32'h0); // Unmapped place reads zero
    check(rd, 32'h0);
    cmd(`SWG_CMD_START);
    check(running_o, 1'b0);
    wb(1'b0, `SWG_A_STATUS, 32'h0);
    check(rd[`SWG_ST_REFUSE], 1'b1);
  endtask : t_idle

  task automatic t_rect;
    wb(1'b1, `SWG_A_CTRL, 32'h2);
    wb(1'b1, `SWG_A_AMPL, AMP);
    wb(1'b1, `SWG_A_OFFS, OFFS);
    wb(1'b1, `SWG_A_T1, 32'h1);
    wb(1'b1, 8'h1C, 32'h1);
    wb(1'b1, `SWG_A_USTAT, ST_U);
    wb(1'b1, `SWG_A_ISTAT, 32'h2000);
    wb(1'b1, `SWG_A_PSTAT, 32'h0300);
    cmd(`SWG_CMD_LOAD);
    check(out_en_o, 1'b1);
    check(u_set_o, ST_U);
    check(p_set_o, 16'h0300);
    wb(1'b1, `SWG_A_AMPL, 32'h50);
    wb(1'b0, `SWG_A_AMPL, 32'h0);
    check(rd, AMP);
    cmd(`SWG_CMD_START);
    check(running_o, 1'b1);
    n = 0;
    while (u_set_o !== OFFS + AMP && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (u_set_o === OFFS + AMP && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
    check(n, 2500);
    check(u_set_o, OFFS);
    check(i_set_o, 16'h2000);
    n = 0;
    while (u_set_o === OFFS && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
    check(n, 2500);
    cmd(`SWG_CMD_STOP);
    check({running_o, out_en_o}, 2'b01);
    check(u_set_o, ST_U);
    cmd(`SWG_CMD_START);
    cmd(`SWG_CMD_ONOFF);
    check({running_o, out_en_o}, 2'b00);
    cmd(`SWG_CMD_ONOFF);
    check({running_o, out_en_o}, 2'b11);
  endtask : t_rect

  // Every alarm source in turn, restarting from the halted state
  task automatic t_alarms;
    for (int s = 1; s <= 4; s++) begin
      if (running_o !== 1'b1) cmd(`SWG_CMD_START);
      @(posedge clk_i);
      trip_sel <= 3'(s);
      n = 0;
      while (out_en_o !== 1'b0 && n < 10) begin
        @(posedge clk_i);
        n++;
      end
      check({running_o, out_en_o, alarm_o}, 3'b001);
      trip_sel <= 3'h0;
      repeat (5) @(posedge clk_i);
      cmd(`SWG_CMD_CLRAL);
      check(alarm_o, 1'b0);
    end
  endtask : t_alarms

  task automatic t_current;
    wb(1'b1, `SWG_A_CTRL, 32'h5);
    wb(1'b1, `SWG_A_USTAT, 32'h0800);
    cmd(`SWG_CMD_LOAD);
    check(i_set_o, 16'h0000);
    cmd(`SWG_CMD_START);
    n = 0;
    repeat (3000) begin
      @(posedge clk_i);
      if (u_set_o !== 16'h0800) n++;
    end
    check(n, 0);
    check(p_set_o, 16'h0300);
    check(i_set_o > OFFS, 1'b1);
    cmd(`SWG_CMD_ONOFF);
  endtask : t_current

  task automatic t_loads;
    resist_mode_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    load_expect(1'b0);
    check(rd[`SWG_ST_REJECT], 1'b1);
    resist_mode_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b1, `SWG_A_CTRL, 32'h0);
    wb(1'b1, `SWG_A_OFFS, 32'h0010);
    load_expect(1'b0);
    check(rd[`SWG_ST_REJECT], 1'b1);
    wb(1'b1, `SWG_A_OFFS, AMP);
    wb(1'b1, `SWG_A_FREQ, 32'd10001);
    load_expect(1'b0);
    check(rd[`SWG_ST_REJECT], 1'b1);
    wb(1'b1, `SWG_A_FREQ, 32'd10000);
    load_expect(1'b1);
    check(rd[`SWG_ST_REJECT], 1'b0);
    check(out_en_o, 1'b1);
  endtask : t_loads

  // Sine loaded above with offset equal to amplitude: one full period
  // must swing from near zero to near twice the amplitude
  task automatic t_sine;
    swg_level_t hi;
    swg_level_t lo;
    hi = 16'h0000;
    lo = 16'hFFFF;
    cmd(`SWG_CMD_START);
    check(running_o, 1'b1);
    repeat (2600) begin
      @(posedge clk_i);
      if (u_set_o > hi) hi = u_set_o;
      if (u_set_o < lo) lo = u_set_o;
    end
    check(hi > 16'h03F0 && hi <= AMP + AMP, 1'b1);
    check(lo < 16'h0010, 1'b1);
    check(i_set_o, 16'h2000);
    cmd(`SWG_CMD_ONOFF);
  endtask : t_sine

  // Trapezoid of four two-tick phases: top run plus the rest is a period
  task automatic t_trap;
    swg_level_t lo;
    int         m;
    logic       mid;
    lo = 16'hFFFF;
    mid = 1'b0;
    wb(1'b1, `SWG_A_CTRL, 32'h3);
    wb(1'b1, `SWG_A_OFFS, OFFS);
    wb(1'b1, `SWG_A_T1, 32'h2);
    wb(1'b1, 8'h1C, 32'h2);
    wb(1'b1, 8'h20, 32'h2);
    wb(1'b1, 8'h24, 32'h2);
    cmd(`SWG_CMD_LOAD);
    cmd(`SWG_CMD_START);
    n = 0;
    while (u_set_o !== OFFS + AMP && n < 30000) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (u_set_o === OFFS + AMP && n < 30000) begin
      @(posedge clk_i);
      n++;
    end
    m = n;
    n = 0;
    while (u_set_o !== OFFS + AMP && n < 30000) begin
      if (u_set_o > OFFS && u_set_o < OFFS + AMP) mid = 1'b1;
      if (u_set_o < lo) lo = u_set_o;
      @(posedge clk_i);
      n++;
    end
    check(m + n, 20000);
    check(lo, OFFS);
    check(mid, 1'b1);
    cmd(`SWG_CMD_ONOFF);
  endtask : t_trap

  // Reset in mid-run clears everything and forgets the loaded waveform
  task automatic t_reset;
    cmd(`SWG_CMD_START);
    check(running_o, 1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({out_en_o, running_o, alarm_o}, 3'b000);
    check({u_set_o, p_set_o}, 32'h00000000);
    check(i_set_o, 16'h0000);
    cmd(`SWG_CMD_START);
    check(running_o, 1'b0);
  endtask : t_reset

  // Ceiling well above the longest expected run
  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    test_done();
  end

  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = 32'h0;
    resist_mode_i = 1'b0;
    trip_sel = 3'h0;
    bad_count = 0;
    total_checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_idle();
    t_rect();
    t_alarms();
    t_current();
    t_loads();
    t_sine();
    t_trap();
    t_reset();
    test_done();
  end
endmodule : swg_core_tb
`default_nettype wire

// ### swg_params.svh
// Address map, field positions, reset values and timing constants
`ifndef SWG_PARAMS_SVH
`define SWG_PARAMS_SVH

`define SWG_A_CTRL    8'h00
`define SWG_A_CMD     8'h04
`define SWG_A_STATUS  8'h08
`define SWG_A_AMPL    8'h0C
`define SWG_A_OFFS    8'h10
`define SWG_A_FREQ    8'h14
`define SWG_A_T1      8'h18
`define SWG_A_USTAT   8'h28
`define SWG_A_ISTAT   8'h2C
`define SWG_A_PSTAT   8'h30

`define SWG_CMD_LOAD  0
`define SWG_CMD_START 1
`define SWG_CMD_STOP  2
`define SWG_CMD_ONOFF 3
`define SWG_CMD_CLRAL 4
`define SWG_CMD_CLRER 5

`define SWG_CTRL_TGT  2

`define SWG_ST_OUT    3
`define SWG_ST_RUN    4
`define SWG_ST_ALARM  5
`define SWG_ST_REFUSE 6
`define SWG_ST_REJECT 7
`define SWG_ST_RMODE  8

`define SWG_RST_LEVEL 16'h0000
`define SWG_RST_FREQ  14'h0001
`define SWG_RST_T     29'h0000001
`define SWG_NOMINAL   17'h0FFFF

`define SWG_CLK_HZ    25000000
`define SWG_CLK_NS    40
`define SWG_TICK_NS   100000
`define SWG_TICK_CYC  (`SWG_TICK_NS / `SWG_CLK_NS)
`define SWG_T_MIN     29'd1
`define SWG_T_MAX_S   36000
`define SWG_T_MAX     29'(`SWG_T_MAX_S * 10000)
`define SWG_F_MIN     14'd1
`define SWG_F_MAX     14'd10000
`define SWG_PH_PER_HZ (((64'd1 << 32) + `SWG_CLK_HZ / 2) / `SWG_CLK_HZ)

`endif

// ### swg_pkg.sv
// Types shared by the set-value waveform generator
`default_nettype none
package swg_pkg;
  typedef logic [31:0] swg_word_t;
  typedef logic [15:0] swg_level_t;
  typedef enum logic [2:0] {
    SWG_IDLE  = 3'b000,
    SWG_LOAD  = 3'b001,
    SWG_ARMED = 3'b011,
    SWG_RUN   = 3'b010,
    SWG_OFF   = 3'b110
  } swg_state_e;
  typedef enum logic [1:0] {
    SWG_SINE = 2'h0,
    SWG_TRI  = 2'h1,
    SWG_RECT = 2'h2,
    SWG_TRAP = 2'h3
  } swg_wave_e;
endpackage : swg_pkg
`default_nettype wire

// ### swg_stage_model.sv
// Behavioural power stage: protection lines seen by the generator
`timescale 1ns/1ps
`default_nettype none
module swg_stage_model (
  // Clock
  input  wire logic       clk_i,
  // Fault selection from the bench, 0 means healthy
  input  wire logic [2:0] trip_sel_i,
  // Protection lines into the generator
  output logic            dev_alarm_o,
  output logic            overpower_trip_o,
  output logic            overcurrent_trip_o,
  output logic            event_alarm_o
);
  // A fault stays raised for as long as the bench holds it, like a real
  // trip that persists until its cause goes away
  always_ff @(posedge clk_i) begin
    dev_alarm_o        <= (trip_sel_i == 3'h1);
    overpower_trip_o   <= (trip_sel_i == 3'h2);
    overcurrent_trip_o <= (trip_sel_i == 3'h3);
    event_alarm_o      <= (trip_sel_i == 3'h4);
  end
endmodule : swg_stage_model
`default_nettype wire
